// ---- rxb4_consts.svh ----
// Overview of operation
// - four bonded channels share one transceiver block
// - bonding offered for pcie x4, xaui, basic x4
// - xaui mode inserts the deskew fifo
// - pcie x4 modes bypass the deskew fifo
// - serial recovered clock is half line rate
// - parallel clock divides serial clock per channel
// - with deskew, aligner uses own recovered clock
// - with deskew, channel 0 clocks deskew, rate-match write
// - with deskew, master clock drives read, decoder, deserializer
// - without deskew, own clock drives aligner, rate-match write
// - without deskew, master clock drives read, decoder, deserializer
// - phase fifo clock: master clock, halved with deserializer
// - phase fifos share pointers and enables from master
// - pcie gen1 full rate needs hard core
`ifndef RXB4_CONSTS_SVH
`define RXB4_CONSTS_SVH

`define RXB4_ADDR_W 8
`define RXB4_DATA_W 32

// register offsets
`define RXB4_REG_CTRL 8'h00
`define RXB4_REG_RATE 8'h04
`define RXB4_REG_BLOCK 8'h08
`define RXB4_REG_STATUS 8'h0C
`define RXB4_REG_FREQ 8'h10
`define RXB4_REG_ROUTE 8'h14
`define RXB4_REG_PTR 8'h18

// control field positions
`define RXB4_CTRL_MODE_LO 0
`define RXB4_CTRL_BDS 2
`define RXB4_CTRL_HARD 3
`define RXB4_CTRL_EN 4

// reset values
`define RXB4_CTRL_RST 5'h00
`define RXB4_RATE_RST 16'h09C4
`define RXB4_BLOCK_RST 8'h00

// serial clock to parallel clock divide (10 bit word, half-rate cdr)
`define RXB4_PAR_DIV 16'h0005
// full-rate pcie gen1 fabric clock in mhz
`define RXB4_PCIE_G1_MHZ 16'h00FA
// phase fifo pointer width and read start distance
`define RXB4_PTR_W 3
`define RXB4_RD_START 3'h2

`endif

// ---- rxb4_pkg.sv ----
package rxb4_pkg;

	typedef enum logic [1:0] {
		RXB4_MODE_PCIE_G1 = 2'h0,
		RXB4_MODE_PCIE_G2 = 2'h1,
		RXB4_MODE_XAUI = 2'h2,
		RXB4_MODE_BASIC = 2'h3
	} rxb4_mode_t;

	typedef enum logic [3:0] {
		RXB4_ST_IDLE = 4'h1,
		RXB4_ST_WAIT = 4'h2,
		RXB4_ST_RUN = 4'h4,
		RXB4_ST_FAULT = 4'h8
	} rxb4_state_t;

endpackage : rxb4_pkg

// ---- rxb4_sync2.sv ----
`timescale 1ns/1ps
// two flip-flop synchroniser for one level
module rxb4_sync2 (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_r;
	logic sync_r;

	// only sync_r reads the first stage
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule : rxb4_sync2

// ---- rxb4_bonded_clocking.sv ----
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rxb4_consts.svh"
// receive clock routing and shared phase fifo control for four bonded lanes
module rxb4_bonded_clocking (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic master_clock_unit_lock,
	input wire logic [3:0] cdr_lock,
	output logic deskew_en,
	output logic [7:0] rmf_wr_src,
	output logic [7:0] aligner_src,
	output logic master_lowspeed_sel,
	output logic bds_wr_en,
	output logic pcf_div2,
	output logic iface_clk_en,
	output logic iface_valid,
	output logic pcf_wr_en,
	output logic pcf_rd_en,
	output logic [2:0] pcf_wr_ptr,
	output logic [2:0] pcf_rd_ptr
);
	logic [4:0] ctrl_r;
	logic [4:0] ctrl_nxt;
	logic [15:0] rate_r;
	logic [15:0] rate_nxt;
	logic [7:0] block_r;
	logic [7:0] block_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	rxb4_pkg::rxb4_state_t state_r;
	rxb4_pkg::rxb4_state_t state_nxt;
	logic phase_r;
	logic phase_nxt;
	logic [2:0] wr_ptr_r;
	logic [2:0] wr_ptr_nxt;
	logic [2:0] rd_ptr_r;
	logic [2:0] rd_ptr_nxt;
	logic rd_go_r;
	logic rd_go_nxt;
	logic [7:0] rmf_src_r;
	logic [7:0] rmf_src_nxt;
	logic deskew_r;
	logic deskew_nxt;
	logic master_sel_r;
	logic master_sel_nxt;
	logic bds_r;
	logic bds_nxt;
	logic div2_r;
	logic div2_nxt;
	logic master_lock_s;
	logic [3:0] cdr_lock_s;
	rxb4_pkg::rxb4_mode_t mode;
	logic mode_xaui;
	logic bond_ok;
	logic mode_ok;
	logic rate_ok;
	logic cfg_ok;
	logic step;
	logic [15:0] serial_mhz;
	logic [15:0] par_mhz;
	logic [15:0] fabric_mhz;

	// pin inputs cross into ref_clk
	rxb4_sync2 u_sync_master (
		.ref_clk(ref_clk),
		.reset(reset),
		.async_in(master_clock_unit_lock),
		.sync_out(master_lock_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_cdr
			rxb4_sync2 u_sync_cdr (
				.ref_clk(ref_clk),
				.reset(reset),
				.async_in(cdr_lock[gi]),
				.sync_out(cdr_lock_s[gi])
			);
		end
	endgenerate

	// configuration decode
	always_comb
	begin
		mode = rxb4_pkg::rxb4_mode_t'(ctrl_r[`RXB4_CTRL_MODE_LO +: 2]);
		mode_xaui = (mode == rxb4_pkg::RXB4_MODE_XAUI);
		// all four lanes in one transceiver block
		bond_ok = (block_r[1:0] == block_r[3:2]) && (block_r[1:0] == block_r[5:4])
			&& (block_r[1:0] == block_r[7:6]);
		// every two-bit code is one of the bondable modes
		mode_ok = 1'b1;
		case (mode)
			rxb4_pkg::RXB4_MODE_PCIE_G1: rate_ok = ctrl_r[`RXB4_CTRL_BDS] || ctrl_r[`RXB4_CTRL_HARD];
			rxb4_pkg::RXB4_MODE_PCIE_G2: rate_ok = ctrl_r[`RXB4_CTRL_BDS];
			rxb4_pkg::RXB4_MODE_XAUI: rate_ok = ctrl_r[`RXB4_CTRL_BDS];
			rxb4_pkg::RXB4_MODE_BASIC: rate_ok = 1'b1;
			default: rate_ok = 1'b0;
		endcase
		cfg_ok = bond_ok && mode_ok && rate_ok;
	end

	// clock frequencies derived from the line rate
	always_comb
	begin
		serial_mhz = {1'b0, rate_r[15:1]};
		par_mhz = serial_mhz / `RXB4_PAR_DIV;
		if (ctrl_r[`RXB4_CTRL_BDS])
			fabric_mhz = {1'b0, par_mhz[15:1]};
		else if (mode == rxb4_pkg::RXB4_MODE_PCIE_G1)
			fabric_mhz = ctrl_r[`RXB4_CTRL_HARD] ? `RXB4_PCIE_G1_MHZ : 16'h0000;
		else
			fabric_mhz = par_mhz;
	end

	// register writes
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		rate_nxt = rate_r;
		block_nxt = block_r;
		if (reg_wr)
		begin
			case (reg_addr)
				`RXB4_REG_CTRL: ctrl_nxt = reg_wdata[4:0];
				`RXB4_REG_RATE: rate_nxt = reg_wdata[15:0];
				`RXB4_REG_BLOCK: block_nxt = reg_wdata[7:0];
				default: ctrl_nxt = ctrl_r;
			endcase
		end
	end

	// register reads, data in the following cycle
	always_comb
	begin
		rdata_nxt = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				`RXB4_REG_CTRL: rdata_nxt = {27'h0000000, ctrl_r};
				`RXB4_REG_RATE: rdata_nxt = {16'h0000, rate_r};
				`RXB4_REG_BLOCK: rdata_nxt = {24'h000000, block_r};
				`RXB4_REG_STATUS: rdata_nxt = {20'h00000, cdr_lock_s, state_r,
					master_lock_s, rate_ok, deskew_r, bond_ok};
				`RXB4_REG_FREQ: rdata_nxt = {serial_mhz, fabric_mhz};
				`RXB4_REG_ROUTE: rdata_nxt = {21'h000000, div2_r, bds_r, master_sel_r, rmf_src_r};
				`RXB4_REG_PTR: rdata_nxt = {25'h0000000, rd_go_r, rd_ptr_r, wr_ptr_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// sequencing: the interface clock waits for the master clock
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			rxb4_pkg::RXB4_ST_IDLE:
			begin
				if (ctrl_r[`RXB4_CTRL_EN])
					state_nxt = cfg_ok ? rxb4_pkg::RXB4_ST_WAIT : rxb4_pkg::RXB4_ST_FAULT;
			end
			rxb4_pkg::RXB4_ST_WAIT:
			begin
				if (!ctrl_r[`RXB4_CTRL_EN])
					state_nxt = rxb4_pkg::RXB4_ST_IDLE;
				else if (!cfg_ok)
					state_nxt = rxb4_pkg::RXB4_ST_FAULT;
				else if (master_lock_s)
					state_nxt = rxb4_pkg::RXB4_ST_RUN;
			end
			rxb4_pkg::RXB4_ST_RUN:
			begin
				if (!ctrl_r[`RXB4_CTRL_EN])
					state_nxt = rxb4_pkg::RXB4_ST_IDLE;
				else if (!cfg_ok)
					state_nxt = rxb4_pkg::RXB4_ST_FAULT;
				else if (!master_lock_s)
					state_nxt = rxb4_pkg::RXB4_ST_WAIT;
			end
			rxb4_pkg::RXB4_ST_FAULT:
			begin
				if (!ctrl_r[`RXB4_CTRL_EN])
					state_nxt = rxb4_pkg::RXB4_ST_IDLE;
			end
			default: state_nxt = rxb4_pkg::RXB4_ST_IDLE;
		endcase
	end

	// clock routing selects, back at reset values outside wait and run
	always_comb
	begin
		deskew_nxt = 1'b0;
		rmf_src_nxt = 8'hE4;
		master_sel_nxt = 1'b0;
		bds_nxt = 1'b0;
		div2_nxt = 1'b0;
		if (state_r == rxb4_pkg::RXB4_ST_RUN || state_r == rxb4_pkg::RXB4_ST_WAIT)
		begin
			deskew_nxt = mode_xaui;
			// lane 0 recovered clock for all writes with deskew, own lane otherwise
			rmf_src_nxt = mode_xaui ? 8'h00 : 8'hE4;
			master_sel_nxt = 1'b1;
			bds_nxt = ctrl_r[`RXB4_CTRL_BDS];
			div2_nxt = ctrl_r[`RXB4_CTRL_BDS];
		end
	end

	// shared phase fifo pointers, one set for all lanes
	always_comb
	begin
		phase_nxt = 1'b0;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		rd_go_nxt = rd_go_r;
		step = 1'b0;
		if (state_r == rxb4_pkg::RXB4_ST_RUN)
		begin
			phase_nxt = ~phase_r;
			step = div2_r ? phase_r : 1'b1;
			if (step)
			begin
				wr_ptr_nxt = wr_ptr_r + 3'h1;
				if (rd_go_r)
					rd_ptr_nxt = rd_ptr_r + 3'h1;
				else if (wr_ptr_r == (`RXB4_RD_START - 3'h1))
					rd_go_nxt = 1'b1;
			end
		end
		else
		begin
			wr_ptr_nxt = 3'h0;
			rd_ptr_nxt = 3'h0;
			rd_go_nxt = 1'b0;
		end
	end

	// registers
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctrl_r <= `RXB4_CTRL_RST;
			rate_r <= `RXB4_RATE_RST;
			block_r <= `RXB4_BLOCK_RST;
			rdata_r <= 32'h00000000;
			state_r <= rxb4_pkg::RXB4_ST_IDLE;
			phase_r <= 1'b0;
			wr_ptr_r <= 3'h0;
			rd_ptr_r <= 3'h0;
			rd_go_r <= 1'b0;
			rmf_src_r <= 8'hE4;
			deskew_r <= 1'b0;
			master_sel_r <= 1'b0;
			bds_r <= 1'b0;
			div2_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			rate_r <= rate_nxt;
			block_r <= block_nxt;
			rdata_r <= rdata_nxt;
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			rd_go_r <= rd_go_nxt;
			rmf_src_r <= rmf_src_nxt;
			deskew_r <= deskew_nxt;
			master_sel_r <= master_sel_nxt;
			bds_r <= bds_nxt;
			div2_r <= div2_nxt;
		end
	end

	// outputs
	assign reg_rdata = rdata_r;
	assign deskew_en = deskew_r;
	assign rmf_wr_src = rmf_src_r;
	assign aligner_src = 8'hE4;
	assign master_lowspeed_sel = master_sel_r;
	assign bds_wr_en = bds_r;
	assign pcf_div2 = div2_r;
	assign iface_valid = (state_r == rxb4_pkg::RXB4_ST_RUN);
	assign iface_clk_en = step;
	assign pcf_wr_en = step;
	assign pcf_rd_en = step && rd_go_r;
	assign pcf_wr_ptr = wr_ptr_r;
	assign pcf_rd_ptr = rd_ptr_r;
endmodule : rxb4_bonded_clocking

// ---- rxb4_sva.sv ----
`timescale 1ns/1ps
// watches lane routing and shared phase fifo control at the block ports
module rxb4_sva (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic master_clock_unit_lock,
	input wire logic deskew_en,
	input wire logic [7:0] rmf_wr_src,
	input wire logic [7:0] aligner_src,
	input wire logic master_lowspeed_sel,
	input wire logic bds_wr_en,
	input wire logic pcf_div2,
	input wire logic iface_clk_en,
	input wire logic iface_valid,
	input wire logic pcf_wr_en,
	input wire logic pcf_rd_en,
	input wire logic [2:0] pcf_wr_ptr
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	chk_own_aligner: assert property (aligner_src == 8'hE4)
		else $error("aligner not on own lane clock");
	chk_xaui_deskew: assert property (deskew_en |-> rmf_wr_src == 8'h00)
		else $error("deskew active but write side not on lane zero");
	chk_lane_write: assert property (!deskew_en |-> rmf_wr_src == 8'hE4)
		else $error("write side not on own lane clock");
	chk_valid_master: assert property (iface_valid |-> master_lowspeed_sel)
		else $error("interface valid without master clock");
	chk_tick_valid: assert property (iface_clk_en |-> iface_valid)
		else $error("interface tick while not valid");
	chk_shared_en: assert property (pcf_wr_en == iface_clk_en)
		else $error("fifo write enable off the interface tick");
	chk_rd_with_wr: assert property (pcf_rd_en |-> pcf_wr_en)
		else $error("fifo read enable without write tick");
	chk_ptr_step: assert property (pcf_wr_en ##1 iface_valid |->
		pcf_wr_ptr == 3'($past(pcf_wr_ptr) + 3'h1))
		else $error("write pointer did not step");
	chk_lock_loss: assert property (!master_clock_unit_lock [*4] |-> !iface_valid)
		else $error("interface valid after master clock loss");
	chk_div_bds: assert property (pcf_div2 |-> bds_wr_en)
		else $error("halved fifo clock without deserializer");
	cover property (iface_valid && deskew_en);
	cover property (pcf_rd_en);
	cover property (pcf_div2 && iface_valid);
endmodule : rxb4_sva

bind rxb4_bonded_clocking rxb4_sva i_sva (.ref_clk, .reset, .master_clock_unit_lock, .deskew_en,
	.rmf_wr_src, .aligner_src, .master_lowspeed_sel, .bds_wr_en, .pcf_div2, .iface_clk_en,
	.iface_valid, .pcf_wr_en, .pcf_rd_en, .pcf_wr_ptr);

// ---- rxb4_fabric_model.sv ----
`timescale 1ns/1ps
// fabric side: counts run cycles and interface clock ticks
module rxb4_fabric_model (
	input wire logic ref_clk,
	input wire logic iface_valid,
	input wire logic iface_clk_en,
	output logic [15:0] run_cycles,
	output logic [15:0] ticks
);
	// all four lanes captured on the one interface tick
	always_ff @(posedge ref_clk)
	begin
		run_cycles <= iface_valid ? run_cycles + 16'h0001 : 16'h0000;
		ticks <= iface_valid ? ticks + 16'(iface_clk_en) : 16'h0000;
	end
endmodule : rxb4_fabric_model

// ---- rxb4_bonded_clocking_tb.sv ----
`timescale 1ns/1ps
`include "rxb4_consts.svh"
// random bonded configurations against the clock routing block
module rxb4_bonded_clocking_tb;
	logic ref_clk, reset, reg_wr, reg_rd, mcu_lock, iface_clk_en, iface_valid;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [3:0] cdr_lock;
	logic [15:0] run_cycles, ticks;
	logic deskew_en, master_lowspeed_sel, bds_wr_en, pcf_div2;
	logic [7:0] rmf_wr_src, aligner_src;
	logic [2:0] pcf_wr_ptr, pcf_rd_ptr;
	int err_total, total_checks;
	int cyc = 0;
	rxb4_bonded_clocking i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .master_clock_unit_lock(mcu_lock), .cdr_lock, .deskew_en, .rmf_wr_src,
		.aligner_src, .master_lowspeed_sel, .bds_wr_en, .pcf_div2, .iface_clk_en,
		.iface_valid, .pcf_wr_en(), .pcf_rd_en(), .pcf_wr_ptr, .pcf_rd_ptr);
	rxb4_fabric_model i_fab (.ref_clk, .iface_valid, .iface_clk_en, .run_cycles, .ticks);
	task print_verdict();
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	// fabric clock in mhz for a legal configuration
	function automatic logic [15:0] fab(logic [1:0] m, logic b, logic h, logic [15:0] r);
		if (b)
			return r / 16'h0014;
		if (m == 2'h0)
			return h ? 16'h00FA : 16'h0000;
		return r / 16'h000A;
	endfunction : fab
	// free running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			print_verdict();
		end
	end
	// main sequence
	initial
	begin : main
		logic [1:0] m;
		logic b, h, ok, bok, rok;
		logic [7:0] blk, rsrc;
		logic [15:0] rate, k;
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		mcu_lock = 1'b0;
		cdr_lock = 4'h0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(32'hD4F3));
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`RXB4_REG_RATE);
		chk("rate reset", 32'h09C4, d);
		rd(8'hFC);
		chk("unmapped", 32'h0, d);
		for (int i = 0; i < 24; i++)
		begin
			m = 2'(i);
			b = 1'($urandom);
			h = 1'($urandom);
			blk = ($urandom_range(3, 0) == 0) ? 8'($urandom) : {4{2'($urandom)}};
			rate = 16'($urandom_range(65535, 1000));
			bok = blk == {4{blk[1:0]}};
			rok = !(m == 2'h0 && !b && !h) && !((m[0] ^ m[1]) && !b);
			ok = bok && rok;
			rsrc = (ok && m == 2'h2) ? 8'h00 : 8'hE4;
			@(posedge ref_clk);
			cdr_lock <= 4'($urandom);
			wr(`RXB4_REG_RATE, {16'h0, rate});
			wr(`RXB4_REG_BLOCK, {24'h0, blk});
			wr(`RXB4_REG_CTRL, {27'h0, 1'b1, h, b, m});
			repeat (3) @(posedge ref_clk);
			rd(`RXB4_REG_STATUS);
			chk("state", ok ? 32'h2 : 32'h8, {28'h0, d[7:4]});
			chk("status", {20'h0, cdr_lock, 5'h0, rok, ok && m == 2'h2, bok}, {20'h0, d[11:8], 4'h0, d[3:0]});
			@(posedge ref_clk);
			mcu_lock <= 1'b1;
			repeat (6) @(posedge ref_clk);
			#1;
			chk("valid", {31'h0, ok}, {31'h0, iface_valid});
			rd(`RXB4_REG_FREQ);
			chk("serial", {16'h0, rate >> 1}, {16'h0, d[31:16]});
			if (ok)
				chk("fabric", {16'h0, fab(m, b, h, rate)}, {16'h0, d[15:0]});
			rd(`RXB4_REG_ROUTE);
			chk("rmf", (ok && m == 2'h2) ? 32'h0 : 32'hE4, {24'h0, d[7:0]});
			chk("sel", ok ? {29'h0, b, b, 1'b1} : 32'h0, {29'h0, d[10:8]});
			chk("pins", {12'h0, ok && m == 2'h2, ok, ok && b, ok && b, rsrc, 8'hE4},
				{12'h0, deskew_en, master_lowspeed_sel, bds_wr_en, pcf_div2, rmf_wr_src, aligner_src});
			repeat ($urandom_range(20, 5)) @(posedge ref_clk);
			#1;
			k = b ? run_cycles >> 1 : run_cycles;
			if (ok)
				chk("ptrs", {26'h0, 3'(k - 16'h0002), 3'(k)}, {26'h0, pcf_rd_ptr, pcf_wr_ptr});
			if (ok)
				chk("ticks", {16'h0, b ? run_cycles >> 1 : run_cycles}, {16'h0, ticks});
			@(posedge ref_clk);
			mcu_lock <= 1'b0;
			repeat (6) @(posedge ref_clk);
			#1;
			chk("lost", 32'h0, {31'h0, iface_valid});
			rd(`RXB4_REG_PTR);
			chk("ptr idle", 32'h0, d);
			rd(`RXB4_REG_BLOCK);
			chk("block", {24'h0, blk}, d);
			wr(`RXB4_REG_CTRL, 32'h0);
			repeat (2) @(posedge ref_clk);
		end
		// reset in the middle of a run returns everything to idle
		wr(`RXB4_REG_BLOCK, 32'h0);
		wr(`RXB4_REG_CTRL, 32'h13);
		@(posedge ref_clk);
		mcu_lock <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		chk("run before reset", 32'h1, {31'h0, iface_valid});
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("reset pins", {16'h0, 1'b0, 8'hE4, 4'h0, 3'h0},
			{16'h0, iface_valid, rmf_wr_src, deskew_en, master_lowspeed_sel, bds_wr_en, pcf_div2, pcf_wr_ptr});
		rd(`RXB4_REG_CTRL);
		chk("ctrl after reset", 32'h0, d);
		rd(`RXB4_REG_RATE);
		chk("rate after reset", 32'h09C4, d);
		print_verdict();
	end
endmodule : rxb4_bonded_clocking_tb
